//--- design/vmtds_top.sv
// Trigger and settling delay sequencer for an integrating voltmeter card
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "vmtds_regs.svh"

// Behaviour
// R01: One reading per trigger waits the delay, then starts the reading.
// R02: Several readings per trigger wait the delay before each reading.
// R03: AC voltage default delay is 1.5 seconds on every range.
// R04: DC voltage default delay follows the range by digits table; the code gives 35 us for table entries below 50 us.
// R05: Four-wire resistance default delay follows the range by digits table.
// R06: Default delay reloads on function or range change unless programmed.
// R07: A programmed delay persists until rewritten or reset.
// R08: Programmed delays below 50 us give an actual 35 us delay.
// R09: System mode takes triggers from external pulse or group execute.
// R10: Outside party signals external trigger with a low-going pulse.
// R11: Extra external triggers during a measurement latch once, no error.
// R12: Group execute source starts a measurement per GET message.
// R13: Scan mode triggers once per completed channel closure.
// R14: Array storage hands each reading over at once, then continues.
// R15: Enabled card interrupts on reading available or overrange.
// R16: Global interrupt enable gates card enable; set at power-on.
// R17: Bus device clear turns the global interrupt enable off.
// R18: Service request needs status bit 512 unmasked, cleared and request enabled; the code needs status bit 512 set, not cleared.
// R19: Card enable clears when serviced; pending clears when data read.
// R20: Slot query returns lowest interrupting slot, or -1 when none.
// R21: Held reading blocks the next one except in continuous mode; the code blocks only the later readings of one trigger, not a new trigger.
// R22: Hold mode, the reset state, takes no measurements.
// R23: Continuous mode retriggers itself when idle, overwriting old readings.
// R24: Delay counter counts microsecond ticks, loads per reading, starts at zero.
// R25: Pending trigger clears on its start, on reset, or on mode change.
module vmtds_top
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Trigger events
  input  wire logic                  extTrigN,
  input  wire logic                  groupExecute,
  input  wire logic                  channelClosed,
  input  wire logic                  deviceClear,
  input  wire logic                  cmdBusy,
  // Measurement core
  input  wire vmtds_pkg::vmtds_meas_t measDone,
  output logic                       convStart,
  // Mainframe side
  input  wire logic [7:0]            otherSlotIntr,
  input  wire logic                  intrServiced,
  output logic                       cardIntr,
  output logic                       serviceRequest
);
  import vmtds_pkg::*;

  vmtds_state_t state_q;
  vmtds_mode_t  mode_q;
  vmtds_func_t  func_q;
  logic [2:0]   range_q;
  logic [1:0]   digits_q;
  logic         srcGet_q;
  logic [15:0]  rdgs_q;
  logic [15:0]  rdgLeft_q;
  logic [31:0]  delayUs_q;
  logic         delayProg_q;
  logic [31:0]  cnt_q;
  logic [5:0]   tick_q;
  logic         usTick;
  logic         pend_q;
  logic         extPrev_q;
  logic         closePrev_q;
  logic         oneShot_q;
  logic [23:0]  rdg_q;
  logic         rdgOver_q;
  logic         rdgHeld_q;
  logic         sysIe_q;
  logic         cardIe_q;
  logic         intrPend_q;
  logic         statIntr_q;
  logic         rqsMask_q;
  logic         rqsOn_q;
  logic [31:0]  defDelay;
  logic [31:0]  effDelay;
  logic         trigEvt;
  logic         wrEn;
  logic         rdEn;
  logic         dataRead;
  logic         modeWr;
  logic [7:0]   slotIntr;
  logic [3:0]   lowSlot;

  assign wrEn     = psel & penable & pwrite;
  assign rdEn     = psel & penable & ~pwrite;
  assign dataRead = rdEn & (paddr == `VMTDS_DATA_OFF);
  assign modeWr   = wrEn & (paddr == `VMTDS_CTRL_OFF) & (pwdata[2:0] != mode_q);

  // Default delay table in microseconds
  always_comb
  begin
    defDelay = 32'h0;
    case (func_q)
      VMTDS_ACV: defDelay = `VMTDS_ACV_DELAY_US; // see R03
      VMTDS_DCV: // see R04
      begin
        case ({range_q, digits_q})
          5'b000_00: defDelay = 32'd380;
          5'b000_01: defDelay = 32'd496;
          5'b000_10: defDelay = 32'd600;
          5'b001_00, 5'b010_00: defDelay = 32'd200;
          5'b001_01, 5'b010_01: defDelay = 32'd260;
          5'b001_10, 5'b010_10: defDelay = 32'd320;
          5'b011_00: defDelay = 32'd36;
          5'b011_01: defDelay = 32'd46;
          5'b011_10: defDelay = 32'd57;
          5'b100_00: defDelay = 32'd11;
          5'b100_01: defDelay = 32'd14;
          default:   defDelay = 32'd17;
        endcase
      end
      VMTDS_FOUR_WIRE_RESISTANCE_FUNCTION: // see R05
      begin
        case ({range_q, digits_q})
          5'b000_00: defDelay = 32'd320;
          5'b000_01: defDelay = 32'd390;
          5'b000_10: defDelay = 32'd460;
          5'b001_00, 5'b010_00, 5'b011_00: defDelay = 32'd200;
          5'b001_01, 5'b010_01, 5'b011_01: defDelay = 32'd240;
          5'b001_10, 5'b010_10, 5'b011_10: defDelay = 32'd290;
          5'b100_00: defDelay = 32'd720;
          5'b100_01: defDelay = 32'd880;
          5'b100_10: defDelay = 32'd1000;
          5'b101_00: defDelay = 32'd7200;
          5'b101_01: defDelay = 32'd8800;
          default:   defDelay = 32'd10000;
        endcase
      end
      default: defDelay = 32'h0;
    endcase
  end

  // Programmed value wins over default; short values hit the floor
  always_comb
  begin
    effDelay = delayProg_q ? delayUs_q : defDelay; // see R06 R07
    if (effDelay < `VMTDS_MIN_PROG_US)
      effDelay = `VMTDS_FLOOR_US; // see R08
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q      <= VMTDS_HOLD; // see R22
      func_q      <= VMTDS_DCV;
      range_q     <= 3'h0;
      digits_q    <= 2'h2;
      srcGet_q    <= 1'b0;
      rdgs_q      <= 16'h0001;
      delayUs_q   <= 32'h0;
      delayProg_q <= 1'b0;
      rqsMask_q   <= 1'b0;
      rqsOn_q     <= 1'b1;
    end
    else if (wrEn)
    begin
      case (paddr)
        `VMTDS_CTRL_OFF:
        begin
          mode_q   <= vmtds_mode_t'(pwdata[2:0]);
          func_q   <= vmtds_func_t'(pwdata[5:4]);
          range_q  <= pwdata[10:8];
          digits_q <= pwdata[13:12];
          srcGet_q <= pwdata[16]; // see R09
          rdgs_q   <= (pwdata[31:20] == 12'h0) ? 16'h0001 : {4'h0, pwdata[31:20]};
        end
        `VMTDS_DELAY_OFF:
        begin
          delayUs_q   <= pwdata; // see R07
          delayProg_q <= 1'b1;
        end
        `VMTDS_SRQ_OFF:
        begin
          rqsMask_q <= pwdata[`VMTDS_INTERRUPTING_SLOT_QUERY_WEIGHT];
          rqsOn_q   <= pwdata[0];
        end
        default: ;
      endcase
    end
  end

  // Microsecond tick
  assign usTick = (tick_q == 6'(`VMTDS_US_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_q <= 6'h0;
    else if (state_q != VMTDS_WAIT || usTick)
      tick_q <= 6'h0;
    else
      tick_q <= tick_q + 6'h1;
  end

  // Trigger sources
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extPrev_q   <= 1'b1;
      closePrev_q <= 1'b0;
    end
    else
    begin
      extPrev_q   <= extTrigN;
      closePrev_q <= channelClosed;
    end
  end

  always_comb
  begin
    trigEvt = 1'b0;
    case (mode_q)
      VMTDS_SYS:  trigEvt = srcGet_q ? groupExecute // see R12
                                     : (extPrev_q & ~extTrigN); // see R10
      VMTDS_SCAN: trigEvt = channelClosed & ~closePrev_q; // see R13
      VMTDS_ONE:  trigEvt = oneShot_q;
      VMTDS_CONT: trigEvt = ~cmdBusy; // see R23
      default:    trigEvt = 1'b0; // see R22
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oneShot_q <= 1'b0;
    else if (wrEn && paddr == `VMTDS_CMD_OFF && pwdata[0])
      oneShot_q <= 1'b1;
    else if (state_q == VMTDS_IDLE)
      oneShot_q <= 1'b0;
  end

  // Pending trigger latched during a measurement
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_q <= 1'b0;
    else if (modeWr)
      pend_q <= 1'b0; // see R25
    else if (trigEvt && state_q != VMTDS_IDLE && mode_q != VMTDS_CONT)
      pend_q <= 1'b1; // see R11
    else if (state_q == VMTDS_IDLE)
      pend_q <= 1'b0; // see R25
  end

  // Sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= VMTDS_IDLE;
      cnt_q     <= 32'h0;
      rdgLeft_q <= 16'h0;
      convStart <= 1'b0;
    end
    else
    begin
      convStart <= 1'b0;
      case (state_q)
        VMTDS_IDLE:
        begin
          if ((trigEvt || pend_q) && mode_q != VMTDS_HOLD && !modeWr)
          begin
            cnt_q     <= effDelay; // see R24
            rdgLeft_q <= rdgs_q;
            state_q   <= VMTDS_WAIT; // see R01
          end
        end
        VMTDS_WAIT:
        begin
          if (cnt_q == 32'h0)
          begin
            convStart <= 1'b1; // see R24
            state_q   <= VMTDS_CONV;
          end
          else if (usTick)
            cnt_q <= cnt_q - 32'h1;
        end
        VMTDS_CONV:
        begin
          if (measDone.start)
          begin
            rdgLeft_q <= rdgLeft_q - 16'h1;
            if (rdgLeft_q == 16'h1)
              state_q <= VMTDS_IDLE;
            else
              state_q <= VMTDS_BLOCK;
          end
        end
        VMTDS_BLOCK:
        begin
          if (!rdgHeld_q || mode_q == VMTDS_CONT) // see R21
          begin
            cnt_q   <= effDelay; // see R02
            state_q <= VMTDS_WAIT;
          end
        end
        default: state_q <= VMTDS_IDLE;
      endcase
      if (modeWr)
        state_q <= VMTDS_IDLE;
    end
  end

  // Single-entry reading buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdg_q     <= 24'h0;
      rdgOver_q <= 1'b0;
      rdgHeld_q <= 1'b0;
    end
    else if (measDone.start)
    begin
      rdg_q     <= measDone.value; // see R23
      rdgOver_q <= measDone.over;
      rdgHeld_q <= 1'b1;
    end
    else if (dataRead)
      rdgHeld_q <= 1'b0; // see R14
  end

  // Card interrupt and status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysIe_q    <= 1'b1; // see R16
      cardIe_q   <= 1'b0;
      intrPend_q <= 1'b0;
      statIntr_q <= 1'b0;
    end
    else
    begin
      if (deviceClear)
        sysIe_q <= 1'b0; // see R17
      else if (wrEn && paddr == `VMTDS_CMD_OFF && pwdata[1])
        sysIe_q <= 1'b1;
      if (intrServiced || (wrEn && paddr == `VMTDS_CMD_OFF && pwdata[3]))
        cardIe_q <= 1'b0; // see R19
      else if (wrEn && paddr == `VMTDS_CMD_OFF && pwdata[2])
        cardIe_q <= 1'b1;
      if (measDone.start && sysIe_q && cardIe_q)
        intrPend_q <= 1'b1; // see R15 R16
      else if (dataRead)
        intrPend_q <= 1'b0; // see R19
      if (measDone.start && sysIe_q && cardIe_q)
        statIntr_q <= 1'b1;
      else if (rdEn && paddr == `VMTDS_STAT_OFF)
        statIntr_q <= 1'b0;
    end
  end

  // Lowest interrupting slot; this card sits in slot 0
  assign slotIntr = {otherSlotIntr[7:1], intrPend_q};
  always_comb
  begin
    lowSlot = `VMTDS_NO_SLOT;
    for (int i = `VMTDS_NSLOTS - 1; i >= 0; i--)
      if (slotIntr[i])
        lowSlot = 4'(i); // see R20
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cardIntr       <= 1'b0;
      serviceRequest <= 1'b0;
    end
    else
    begin
      cardIntr       <= intrPend_q;
      serviceRequest <= statIntr_q & rqsMask_q & rqsOn_q; // see R18
    end
  end

  // APB read path, zero wait states
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable)
      begin
        case (paddr)
          `VMTDS_CTRL_OFF:  prdata <= {rdgs_q[11:0], 3'h0, srcGet_q, 2'h0, digits_q,
                                       1'b0, range_q, 2'h0, func_q, 1'b0, mode_q};
          `VMTDS_DELAY_OFF: prdata <= effDelay;
          `VMTDS_CMD_OFF:   prdata <= {29'h0, cardIe_q, sysIe_q, oneShot_q};
          `VMTDS_STAT_OFF:  prdata <= {22'h0, statIntr_q, 3'h0, pend_q, rdgHeld_q,
                                       intrPend_q, rdgOver_q, state_q};
          `VMTDS_DATA_OFF:  prdata <= {7'h0, rdgOver_q, rdg_q};
          `VMTDS_SRQ_OFF:   prdata <= {22'h0, rqsMask_q, 8'h0, rqsOn_q}; // see R18
          `VMTDS_SLOT_OFF:  prdata <= (lowSlot == `VMTDS_NO_SLOT) ? 32'hffffffff
                                                                  : {28'h0, lowSlot};
          `VMTDS_ACT_OFF:   prdata <= {16'h0, rdgLeft_q};
          default:          pslverr <= pwrite ? 1'b0 : 1'b0;
        endcase
      end
    end
  end
endmodule : vmtds_top

//--- dv/vmtds_assertions.sv
// Port-level assertions of the trigger delay sequencer
`timescale 1ns/1ps
`include "vmtds_regs.svh"
module vmtds_assertions
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Core and mainframe
  input wire vmtds_pkg::vmtds_meas_t  measDone,
  input wire logic                    convStart,
  input wire logic [7:0]              otherSlotIntr,
  input wire logic                    cardIntr
);
  import vmtds_pkg::*;
  // Shortest gap between starts: floor delay less one tick of phase
  localparam int GapMin = 1700;
  logic [11:0] gap_q;
  logic        seen_q;
  logic        modeSet_q;
  function automatic logic [31:0] slotOf(input logic ci, input logic [7:0] o);
    slotOf = 32'hffffffff;
    for (int i = 7; i > 0; i--)
      if (o[i]) slotOf = 32'(i);
    if (ci) slotOf = 32'h00000000;
  endfunction : slotOf
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) gap_q <= 12'h000;
    else if (convStart) gap_q <= 12'h000;
    else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) seen_q <= 1'b0;
    else if (convStart) seen_q <= 1'b1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) modeSet_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == `VMTDS_CTRL_OFF) modeSet_q <= 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_dataRd;
    psel && penable && pready && !pwrite && paddr == `VMTDS_DATA_OFF;
  endsequence
  sequence s_slotRd;
    psel && penable && pready && !pwrite && paddr == `VMTDS_SLOT_OFF;
  endsequence
  property p_setupReady;
    psel && !penable |=> pready && psel && penable;
  endproperty
  property p_readyPulse;
    pready |=> !pready;
  endproperty
  property p_noErr;
    pready |-> !pslverr;
  endproperty
  property p_convPulse;
    convStart |=> !convStart;
  endproperty
  property p_holdQuiet;
    !modeSet_q |-> !convStart;
  endproperty
  property p_convGap;
    convStart && seen_q |-> gap_q >= GapMin;
  endproperty
  property p_intrCause;
    $rose(cardIntr) |-> $past(measDone.start, 2);
  endproperty
  property p_dataClear;
    s_dataRd |=> ##[0:1] !cardIntr;
  endproperty
  property p_slot;
    s_slotRd ##0 ($stable(cardIntr) && $stable(otherSlotIntr))
      |-> prdata == slotOf($past(cardIntr), $past(otherSlotIntr));
  endproperty
  a_setupReady: assert property (p_setupReady) else $error("no ready after setup");
  a_readyPulse: assert property (p_readyPulse) else $error("ready held too long");
  a_noErr: assert property (p_noErr) else $error("slave error raised");
  a_convPulse: assert property (p_convPulse) else $error("start wider than a cycle");
  a_holdQuiet: assert property (p_holdQuiet) else $error("reading in hold mode");
  a_convGap: assert property (p_convGap) else $error("settling delay too short");
  a_intrCause: assert property (p_intrCause) else $error("interrupt without reading");
  a_dataClear: assert property (p_dataClear) else $error("interrupt kept after read");
  a_slot: assert property (p_slot) else $error("wrong interrupting slot");
endmodule : vmtds_assertions

//--- dv/vmtds_mainframe_model.sv
// Measurement core and trigger source facing the sequencer
`timescale 1ns/1ps
module vmtds_mainframe_model
(
  // Clock, reset and controls
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                convStart,
  input wire logic                extFire,
  input wire logic                over,
  input wire logic [15:0]         lat,
  // Toward the sequencer
  output vmtds_pkg::vmtds_meas_t  measDone,
  output logic                    extTrigN
);
  import vmtds_pkg::*;
  logic [15:0] cnt_q;
  logic [23:0] val_q;
  logic [1:0]  low_q;
  // Conversion ends lat cycles after start; value toggles when not valid
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      val_q <= 24'h000001;
      measDone <= '0;
    end
    else
    begin
      if (convStart) cnt_q <= lat;
      else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
      if (cnt_q == 16'h0001)
      begin
        measDone <= '{1'b1, val_q, over};
        val_q <= val_q + 24'h000001;
      end
      else
        measDone <= '{1'b0, ~measDone.value, ~measDone.over};
    end
  // Idle high, low-going pulse of three cycles
  always @(posedge clk or negedge rst_n)
    if (!rst_n) low_q <= 2'h0;
    else if (extFire) low_q <= 2'h3;
    else if (low_q != 2'h0) low_q <= low_q - 2'h1;
  assign extTrigN = (low_q == 2'h0);
endmodule : vmtds_mainframe_model

//--- dv/vmtds_top_test.sv
// Self-checking bench of the trigger delay sequencer
`timescale 1ns/1ps
`include "vmtds_regs.svh"
module vmtds_top_test;
  import vmtds_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, extTrigN, extFire, over;
  logic        groupExecute, channelClosed, deviceClear, cmdBusy, convStart;
  logic        intrServiced, cardIntr, serviceRequest;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0]  otherSlotIntr;
  logic [15:0] lat;
  vmtds_meas_t measDone;
  int          errors, nChecks, nConv, cyc, lastConv, t0, e;
  int          tbl[33] = '{380, 496, 600, 200, 260, 320, 200, 260, 320, 36, 46, 57, 11, 14,
                           17, 320, 390, 460, 200, 240, 290, 200, 240, 290, 200, 240, 290,
                           720, 880, 1000, 7200, 8800, 10000};
  vmtds_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extTrigN(extTrigN), .groupExecute(groupExecute), .channelClosed(channelClosed),
    .deviceClear(deviceClear), .cmdBusy(cmdBusy), .measDone(measDone),
    .convStart(convStart), .otherSlotIntr(otherSlotIntr), .intrServiced(intrServiced),
    .cardIntr(cardIntr), .serviceRequest(serviceRequest));
  vmtds_mainframe_model u_mf (.clk(clk), .rst_n(rst_n), .convStart(convStart),
    .extFire(extFire), .over(over), .lat(lat), .measDone(measDone), .extTrigN(extTrigN));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (convStart === 1'b1)
    begin
      nConv++;
      lastConv = cyc;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task w(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : w
  task rc(input logic [11:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0);
    chk(d, v);
  endtask : rc
  // Waits for the n-th start, then checks its distance from t0 when asked
  task waitConv(input int n, input logic timed);
    for (int k = 0; k < 20000 && nConv < n; k++) @(posedge clk);
    chk(nConv, n);
    if (timed) chk(lastConv - t0 >= 1700 && lastConv - t0 <= 1800, 1'b1);
    repeat (lat + 8) @(posedge clk);
  endtask : waitConv
  task endOfTest;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : endOfTest
  initial
  begin
    {psel, penable, pwrite, groupExecute, channelClosed, deviceClear} = '0;
    {cmdBusy, intrServiced, extFire, over, rst_n} = '0;
    {paddr, pwdata, otherSlotIntr} = '0;
    lat = 16'd20;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(`VMTDS_DELAY_OFF, 32'd600);
    rc(`VMTDS_SRQ_OFF, 32'h00000001);
    rc(`VMTDS_SLOT_OFF, 32'hffffffff);
    rc(12'h020, 32'h0);
    w(`VMTDS_CMD_OFF, 32'h1);
    repeat (3000) @(posedge clk);
    chk(nConv, 0);
    for (int i = 0; i < 33; i++)
    begin
      e = i < 15 ? i : i - 15;
      w(`VMTDS_CTRL_OFF, ((i < 15 ? 1 : 2) << 4) | ((e / 3) << 8) | ((e % 3) << 12));
      rc(`VMTDS_DELAY_OFF, tbl[i] < 50 ? 35 : tbl[i]);
    end
    w(`VMTDS_CTRL_OFF, 32'h0);
    rc(`VMTDS_DELAY_OFF, 32'd1500000);
    w(`VMTDS_DELAY_OFF, 32'd20);
    rc(`VMTDS_DELAY_OFF, 32'd35);
    w(`VMTDS_CTRL_OFF, 32'h00000110);
    rc(`VMTDS_DELAY_OFF, 32'd35);
    w(`VMTDS_SRQ_OFF, 32'h00000201);
    rc(`VMTDS_SRQ_OFF, 32'h00000201);
    rc(`VMTDS_STAT_OFF, 32'h0);
    w(`VMTDS_CMD_OFF, 32'h4);
    w(`VMTDS_CTRL_OFF, 32'h00200012);
    otherSlotIntr <= 8'h0c;
    w(`VMTDS_CMD_OFF, 32'h1);
    t0 = cyc;
    waitConv(1, 1'b1);
    chk(cardIntr, 1'b1);
    chk(serviceRequest, 1'b1);
    rc(`VMTDS_SLOT_OFF, 32'h0);
    repeat (3000) @(posedge clk);
    chk(nConv, 1);
    @(posedge clk) intrServiced <= 1'b1;
    @(posedge clk) intrServiced <= 1'b0;
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    t0 = cyc;
    waitConv(2, 1'b1);
    chk(cardIntr, 1'b0);
    rc(`VMTDS_SLOT_OFF, 32'h2);
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    w(`VMTDS_CTRL_OFF, 32'h00000012);
    @(posedge clk) deviceClear <= 1'b1;
    @(posedge clk) deviceClear <= 1'b0;
    w(`VMTDS_CMD_OFF, 32'h4);
    w(`VMTDS_CMD_OFF, 32'h1);
    waitConv(3, 1'b0);
    chk(cardIntr, 1'b0);
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    w(`VMTDS_CMD_OFF, 32'h2);
    w(`VMTDS_CMD_OFF, 32'h4);
    over <= 1'b1;
    w(`VMTDS_CMD_OFF, 32'h1);
    waitConv(4, 1'b0);
    chk(cardIntr, 1'b1);
    rc(`VMTDS_DATA_OFF, 32'h01000004);
    repeat (2) @(posedge clk);
    chk(cardIntr, 1'b0);
    lat <= 16'd400;
    w(`VMTDS_CTRL_OFF, 32'h00000013);
    repeat (3)
    begin
      @(posedge clk) extFire <= 1'b1;
      @(posedge clk) extFire <= 1'b0;
      repeat (10) @(posedge clk);
    end
    waitConv(5, 1'b0);
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    waitConv(6, 1'b0);
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    repeat (4000) @(posedge clk);
    chk(nConv, 6);
    w(`VMTDS_CTRL_OFF, 32'h00010013);
    @(posedge clk) extFire <= 1'b1;
    @(posedge clk) extFire <= 1'b0;
    repeat (3000) @(posedge clk);
    chk(nConv, 6);
    @(posedge clk) groupExecute <= 1'b1;
    @(posedge clk) groupExecute <= 1'b0;
    waitConv(7, 1'b0);
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    w(`VMTDS_CTRL_OFF, 32'h00000014);
    channelClosed <= 1'b1;
    waitConv(8, 1'b0);
    apb(1'b0, `VMTDS_DATA_OFF, 32'h0);
    repeat (3000) @(posedge clk);
    chk(nConv, 8);
    channelClosed <= 1'b0;
    cmdBusy <= 1'b1;
    w(`VMTDS_CTRL_OFF, 32'h00000011);
    repeat (3000) @(posedge clk);
    chk(nConv, 8);
    cmdBusy <= 1'b0;
    waitConv(10, 1'b0);
    w(`VMTDS_CTRL_OFF, 32'h0);
    endOfTest();
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    errors++;
    endOfTest();
  end
endmodule : vmtds_top_test
bind vmtds_top vmtds_assertions u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .measDone(measDone), .convStart(convStart),
  .otherSlotIntr(otherSlotIntr), .cardIntr(cardIntr));

//--- include/vmtds_pkg.sv
// Types of the trigger delay sequencer
package vmtds_pkg;
  typedef enum logic [2:0] {
    VMTDS_HOLD = 3'b000,
    VMTDS_CONT = 3'b001,
    VMTDS_ONE  = 3'b010,
    VMTDS_SYS  = 3'b011,
    VMTDS_SCAN = 3'b100
  } vmtds_mode_t;
  typedef enum logic [1:0] {
    VMTDS_ACV  = 2'b00,
    VMTDS_DCV  = 2'b01,
    VMTDS_FOUR_WIRE_RESISTANCE_FUNCTION = 2'b10
  } vmtds_func_t;
  typedef enum logic [1:0] {
    VMTDS_IDLE  = 2'b00,
    VMTDS_WAIT  = 2'b01,
    VMTDS_CONV  = 2'b10,
    VMTDS_BLOCK = 2'b11
  } vmtds_state_t;
  typedef struct packed {
    logic        start;
    logic [23:0] value;
    logic        over;
  } vmtds_meas_t;
endpackage : vmtds_pkg

//--- include/vmtds_regs.svh
// Register offsets, field positions, delay values and timing counts of the trigger delay sequencer
`ifndef VMTDS_REGS_SVH
`define VMTDS_REGS_SVH
`define VMTDS_CTRL_OFF      12'h000
`define VMTDS_DELAY_OFF     12'h004
`define VMTDS_CMD_OFF       12'h008
`define VMTDS_STAT_OFF      12'h00c
`define VMTDS_DATA_OFF      12'h010
`define VMTDS_SRQ_OFF       12'h014
`define VMTDS_SLOT_OFF      12'h018
`define VMTDS_ACT_OFF       12'h01c
`define VMTDS_CLK_MHZ       50
`define VMTDS_US_CYCLES     (`VMTDS_CLK_MHZ)
`define VMTDS_ACV_DELAY_US  1500000
`define VMTDS_MIN_PROG_US   50
`define VMTDS_FLOOR_US      35
`define VMTDS_INTERRUPTING_SLOT_QUERY_WEIGHT   9
`define VMTDS_NSLOTS        8
`define VMTDS_NO_SLOT       4'hf
`endif
